// ==== board_model.sv ====
`timescale 1ns/1ps
module board_model (
  input wire logic       clock,
  input wire logic       hold,
  input wire logic       pull_low,
  input wire logic [1:0] ratio_w,
  input wire logic [2:0] boot_w,
  input wire logic       reset_pin_o,
  input wire logic       reset_pin_oe,
  output logic           reset_in_n,
  output logic [1:0]     ratio_sel,
  output logic [2:0]     boot_mode_sel,
  output logic           reset_pin_i
);
  initial begin
    reset_in_n = 1'b0;
    ratio_sel = 2'h0;
    boot_mode_sel = 3'h0;
  end
  always @(posedge clock) begin
    reset_in_n <= !hold;
    // Straps move only inside reset, so they are steady whenever it releases
    if (!reset_in_n) begin
      ratio_sel <= ratio_w;
      boot_mode_sel <= boot_w;
    end
  end
  // Pull-up wins when nobody drives the pin low
  assign reset_pin_i = reset_pin_oe ? reset_pin_o : !pull_low;
endmodule

// ==== lock_timer.sv ====
`timescale 1ns/1ps
module lock_timer #(
  parameter int unsigned WAIT_CYCLES = startup_pkg::LOCK_WAIT_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic hold,
  output logic      done
);
  import startup_pkg::*;

  logic [LOCK_CNT_W-1:0] cnt_q;
  logic [LOCK_CNT_W-1:0] cnt_d;
  logic                  done_q;
  logic                  done_d;

  always_comb begin
    cnt_d  = cnt_q;
    done_d = done_q;
    if (hold) begin
      cnt_d  = '0;
      done_d = 1'b0;
    end else if (!done_q) begin
      if (cnt_q == LOCK_CNT_W'(WAIT_CYCLES - 1)) begin
        done_d = 1'b1;
      end
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;
endmodule

// ==== startup_chk.sv ====
`timescale 1ns/1ps
module startup_chk import startup_pkg::*; #(
  parameter int unsigned LOCK_WAIT    = 16,
  parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        reset_in_n,
  input wire logic        soft_reset,
  input wire logic [1:0]  ratio_sel,
  input wire logic        pll_wr,
  input wire logic [7:0]  pll_mult_wdata,
  input wire logic        runrst_wr,
  input wire logic        runrst_wdata,
  input wire logic        reset_pin_o,
  input wire logic        reset_pin_oe,
  input wire logic [7:0]  pll_mult,
  input wire logic        core_run,
  input wire logic        fetch_start,
  input wire logic [31:0] fetch_addr,
  input wire logic        running_reset_en,
  input wire logic        running_reset_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Counts edges spent released but not yet running
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  always_comb cnt_d = (!reset_in_n || soft_reset || running_reset_req || core_run) ? 16'h0000
                      : cnt_q + 16'h0001;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) cnt_q <= 16'h0000;
    else cnt_q <= cnt_d;
  end
  // No reset of any kind is pending in this cycle
  logic quiet;
  assign quiet = reset_in_n && !soft_reset && !running_reset_req;
  ////////////////////////////////////////////////////////////
  property p_lock; $rose(core_run) |-> cnt_q == LOCK_WAIT + 2; endproperty
  a_lock: assert property (p_lock) else $error("lock wait length wrong");
  property p_vec; $rose(core_run) |-> fetch_start && fetch_addr == RESET_VECTOR; endproperty
  a_vec: assert property (p_vec) else $error("fetch start wrong");
  property p_pulse; fetch_start |=> !fetch_start; endproperty
  a_pulse: assert property (p_pulse) else $error("fetch pulse too long");
  property p_stay; fetch_start && quiet |=> core_run; endproperty
  a_stay: assert property (p_stay) else $error("core left run without reset");
  property p_rout; reset_pin_o == core_run; endproperty
  a_rout: assert property (p_rout) else $error("reset output level wrong");
  property p_hold; !reset_in_n |=> !reset_pin_o && !core_run; endproperty
  a_hold: assert property (p_hold) else $error("reset output released in reset");
  property p_oe; reset_pin_oe == !running_reset_en; endproperty
  a_oe: assert property (p_oe) else $error("pin direction wrong");
  property p_en;
    core_run && quiet && runrst_wr |=> running_reset_en == $past(runrst_wdata);
  endproperty
  a_en: assert property (p_en) else $error("pin mode write lost");
  property p_pm; core_run && quiet && pll_wr |=> pll_mult == $past(pll_mult_wdata); endproperty
  a_pm: assert property (p_pm) else $error("multiplier write lost");
  property p_strap;
    $rose(core_run) |-> pll_mult == (ratio_sel == 2'h1 ? MULT_32 : ratio_sel == 2'h2 ? MULT_16
                                     : MULT_8);
  endproperty
  a_strap: assert property (p_strap) else $error("strap ratio wrong");
  c_run: cover property ($rose(core_run));
  c_rr: cover property ($rose(running_reset_req));
  c_pm: cover property (core_run && pll_wr);
  c_out: cover property (core_run && runrst_wr && !runrst_wdata);
endmodule
bind startup_clock_reset_control startup_chk #(.LOCK_WAIT(LOCK_WAIT), .RESET_VECTOR(RESET_VECTOR))
  chk (.*);

// ==== startup_clock_reset_control.sv ====
`timescale 1ns/1ps
// How it works
// - Ratio straps pick 8, 32 or 16 times
// - Software reloads multiplier and divider after reset
// - Hold core 4098 reference cycles after release (4096-cycle lock wait plus 2)
// - Then fetch starts at the reset vector
// - Dual pin acts as reset output by default
// - Control bit 0 turns pin into reset input
module startup_clock_reset_control #(
  parameter int unsigned         LOCK_WAIT    = startup_pkg::LOCK_WAIT_CYCLES,
  parameter logic [31:0]         RESET_VECTOR = startup_pkg::RESET_VECTOR_DEFAULT
) (
  input  wire logic                               clock,
  input  wire logic                               rst,
  input  wire logic                               reset_in_n,
  input  wire logic                               soft_reset,
  input  wire logic [1:0]                         ratio_sel,
  input  wire logic [startup_pkg::BOOT_MODE_W-1:0] boot_mode_sel,
  input  wire logic                               pll_wr,
  input  wire logic [7:0]                         pll_mult_wdata,
  input  wire logic [7:0]                         pll_div_wdata,
  input  wire logic                               runrst_wr,
  input  wire logic                               runrst_wdata,
  input  wire logic                               reset_pin_i,
  output logic                                    reset_pin_o,
  output logic                                    reset_pin_oe,
  output logic [7:0]                              pll_mult,
  output logic [7:0]                              pll_div,
  output logic                                    ratio_reserved,
  output logic [startup_pkg::BOOT_MODE_W-1:0]     boot_mode,
  output logic                                    core_run,
  output logic                                    fetch_start,
  output logic [31:0]                             fetch_addr,
  output logic                                    running_reset_en,
  output logic                                    running_reset_req
);
  import startup_pkg::*;

  typedef enum logic [1:0] {ST_RESET, ST_LOCK, ST_RUN} state_t;

  function automatic logic [7:0] ratio_mult(input logic [1:0] sel);
    case (sel)
      RATIO_SEL_8:  ratio_mult = MULT_8;
      RATIO_SEL_32: ratio_mult = MULT_32;
      RATIO_SEL_16: ratio_mult = MULT_16;
      default:      ratio_mult = MULT_8;
    endcase
  endfunction

  function automatic logic ratio_is_reserved(input logic [1:0] sel);
    ratio_is_reserved = (sel == RATIO_SEL_RSV);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  state_t                 state_q;
  state_t                 state_d;
  logic                   fetch_q;
  logic                   fetch_d;
  logic                   pin_q;
  logic                   pin_d;
  logic [31:0]            addr_q;
  logic [31:0]            addr_d;
  logic                   lock_done;
  logic                   any_reset;
  logic                   capture;
  logic                   sw_write_ok;
  // Clock settings, caught from the straps or written by software
  logic [7:0]             mult_q;
  logic [7:0]             mult_d;
  logic [7:0]             div_q;
  logic [7:0]             div_d;
  logic                   rsv_q;
  logic                   rsv_d;
  logic [BOOT_MODE_W-1:0] boot_q;
  logic [BOOT_MODE_W-1:0] boot_d;
  // Pin mode
  logic                   runrst_q;
  logic                   runrst_d;
  logic                   rrq_q;
  logic                   rrq_d;

  // A running reset from the pin restarts the core but keeps the pin mode
  assign any_reset   = !reset_in_n || soft_reset || rrq_q;
  // Straps are caught on release, after they have settled
  assign capture     = (state_q == ST_RESET) && !any_reset;
  // Writes during reset or lock wait are dropped, not queued
  assign sw_write_ok = (state_q == ST_RUN) && !any_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Lock wait timer
  lock_timer #(
    .WAIT_CYCLES (LOCK_WAIT)
  ) u_lock_timer (
    .clock (clock),
    .rst   (rst),
    .hold  (state_q != ST_LOCK),
    .done  (lock_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d = state_q;
    fetch_d = 1'b0;
    addr_d  = addr_q;
    case (state_q)
      ST_RESET: begin
        if (!any_reset) begin
          state_d = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (any_reset) begin
          state_d = ST_RESET;
        end else if (lock_done) begin
          state_d = ST_RUN;
          fetch_d = 1'b1;
        end
      end
      ST_RUN: begin
        if (any_reset) begin
          state_d = ST_RESET;
        end
      end
      default: state_d = ST_RESET;
    endcase
    // Pin low through reset and lock wait; registered so it cannot glitch
    pin_d = (state_d == ST_RUN);
    // Address is registered so it is settled when the strobe rises
    if (fetch_d) begin
      addr_d = RESET_VECTOR;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_RESET;
      fetch_q <= 1'b0;
      pin_q   <= 1'b0;
      addr_q  <= '0;
    end else begin
      state_q <= state_d;
      fetch_q <= fetch_d;
      pin_q   <= pin_d;
      addr_q  <= addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock settings
  always_comb begin
    mult_d = mult_q;
    div_d  = div_q;
    rsv_d  = rsv_q;
    boot_d = boot_q;
    if (capture) begin
      mult_d = ratio_mult(ratio_sel);
      rsv_d  = ratio_is_reserved(ratio_sel);
      div_d  = DIV_RESET;
      boot_d = boot_mode_sel;
    end else if (sw_write_ok && pll_wr) begin
      mult_d = pll_mult_wdata;
      div_d  = pll_div_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mult_q <= MULT_8;
      div_q  <= DIV_RESET;
      rsv_q  <= 1'b0;
      boot_q <= '0;
    end else begin
      mult_q <= mult_d;
      div_q  <= div_d;
      rsv_q  <= rsv_d;
      boot_q <= boot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin mode
  always_comb begin
    runrst_d = runrst_q;
    rrq_d    = runrst_q && !reset_pin_i;
    if (sw_write_ok && runrst_wr) begin
      runrst_d = runrst_wdata;
    end
    // Hardware reset puts the pin back to output mode
    if (!reset_in_n) begin
      runrst_d = 1'b0;
      rrq_d    = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      runrst_q <= 1'b0;
      rrq_q    <= 1'b0;
    end else begin
      runrst_q <= runrst_d;
      rrq_q    <= rrq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign core_run          = (state_q == ST_RUN);
  assign fetch_start       = fetch_q;
  assign fetch_addr        = addr_q;
  assign pll_mult          = mult_q;
  assign pll_div           = div_q;
  assign ratio_reserved    = rsv_q;
  assign boot_mode         = boot_q;
  assign running_reset_en  = runrst_q;
  assign running_reset_req = rrq_q;
  // Pin drives low while core is held; released to input in running-reset mode
  assign reset_pin_oe      = !runrst_q;
  assign reset_pin_o       = pin_q;
endmodule

// ==== startup_pkg.sv ====
package startup_pkg;
  // Ratio strap patterns
  localparam logic [1:0] RATIO_SEL_8   = 2'h0;
  localparam logic [1:0] RATIO_SEL_32  = 2'h1;
  localparam logic [1:0] RATIO_SEL_16  = 2'h2;
  localparam logic [1:0] RATIO_SEL_RSV = 2'h3;
  // Multiplier codes produced for each strap pattern
  localparam logic [7:0] MULT_8  = 8'h08;
  localparam logic [7:0] MULT_16 = 8'h10;
  localparam logic [7:0] MULT_32 = 8'h20;
  localparam logic [7:0] DIV_RESET = 8'h01;
  // Lock wait in reference clock cycles
  localparam int unsigned LOCK_WAIT_CYCLES = 4096;
  localparam int unsigned LOCK_CNT_W       = 13;
  // Running-reset control bit position
  localparam int unsigned RUNRST_EN_BIT = 0;
  localparam logic [31:0] RESET_VECTOR_DEFAULT = 32'h0009_0000;
  localparam int unsigned BOOT_MODE_W = 3;
endpackage

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import startup_pkg::*;
  localparam int unsigned LW = 16;
  logic clock = 1'b0, rst = 1'b1, hold = 1'b1, pull_low = 1'b0, soft_reset = 1'b0;
  logic pll_wr = 1'b0, runrst_wr = 1'b0, runrst_wdata = 1'b0;
  logic [1:0] ratio_w = 2'h0, ratio_sel;
  logic [2:0] boot_w = 3'h0, boot_mode_sel, boot_mode;
  logic [7:0] pll_mult_wdata = 8'h00, pll_div_wdata = 8'h00, pll_mult, pll_div;
  logic reset_in_n, reset_pin_i, reset_pin_o, reset_pin_oe, ratio_reserved, core_run;
  logic fetch_start, running_reset_en, running_reset_req;
  logic [31:0] fetch_addr;
  int failures = 0, check_count = 0;
  always #5 clock = ~clock;
  board_model board (.*);
  startup_clock_reset_control #(.LOCK_WAIT(LW), .RESET_VECTOR(RESET_VECTOR_DEFAULT)) DUT (.*);
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_mult(input logic [1:0] r);
    return r == 2'h1 ? MULT_32 : r == 2'h2 ? MULT_16 : MULT_8;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_run();
    for (int i = 0; i < 4 * LW && core_run !== 1'b1; i++) tick(1);
    chk(core_run, 1'b1);
  endtask
  task automatic boot(input logic [1:0] r);
    ratio_w = r;
    boot_w = 3'($urandom);
    hold = 1'b1;
    tick(3);
    chk(reset_pin_o, 1'b0);
    hold = 1'b0;
    // Writes before run must be ignored
    pll_wr = 1'b1;
    pll_mult_wdata = 8'($urandom);
    tick(LW / 2);
    pll_wr = 1'b0;
    chk(core_run, 1'b0);
    wait_run();
    chk(pll_mult, exp_mult(r));
    chk(ratio_reserved, r == 2'h3);
    chk({pll_div, boot_mode}, {DIV_RESET, boot_w});
    chk(fetch_addr, RESET_VECTOR_DEFAULT);
    chk({reset_pin_oe, reset_pin_o}, 2'h3);
  endtask
  initial begin
    void'($urandom(32'h849b_7ddb));
    tick(12);
    rst = 1'b0;
    for (int r = 0; r < 4; r++) boot(2'(r));
    repeat (3) begin
      pll_wr = 1'b1;
      pll_mult_wdata = 8'($urandom);
      pll_div_wdata = 8'($urandom);
      tick(1);
      chk({pll_mult, pll_div}, {pll_mult_wdata, pll_div_wdata});
    end
    pll_wr = 1'b0;
    runrst_wr = 1'b1;
    runrst_wdata = 1'b1;
    tick(1);
    runrst_wr = 1'b0;
    chk(reset_pin_oe, 1'b0);
    pull_low = 1'b1;
    tick(1);
    pull_low = 1'b0;
    chk(running_reset_req, 1'b1);
    tick(2);
    chk(core_run, 1'b0);
    wait_run();
    chk(running_reset_en, 1'b1);
    runrst_wr = 1'b1;
    runrst_wdata = 1'b0;
    tick(1);
    chk(reset_pin_oe, 1'b1);
    runrst_wdata = 1'b1;
    tick(1);
    runrst_wr = 1'b0;
    chk(reset_pin_oe, 1'b0);
    // Second pass lands inside the lock wait and must restart it
    repeat (2) begin
      soft_reset = 1'b1;
      tick(1);
      soft_reset = 1'b0;
      chk(core_run, 1'b0);
      tick(4);
    end
    wait_run();
    boot(2'($urandom));
    stop_test();
  end
  initial begin
    #50000;
    failures++;
    stop_test();
  end
  task automatic stop_test();
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
endmodule
